// [timer_clock_select.sv]
// timer clock selection, prescaler and two 16-bit auto-reload / capture timers
// Contract
// - timer 3 high byte clock, split mode only
// - timer 1 clock: prescaled or system clock
// - timer 0 clock: prescaled or system clock
// - prescale codes: /12, /4, /48, external/8
// - timer 2 reload bytes hold captures too
// - timer 2 high byte reads count upper byte
// - timer 3 mode from split and capture bits
// - timer 3 clock: system, /12, external/8
// - external divided-by-8 synchronised before use
// - 16-bit rollover reloads and sets high flag
// - 16-bit overflow interrupts when enabled
// - low-byte rollover interrupts when enabled
// - frame capture, 16-bit free count, copy bytes
// - frame capture split, bytes wrap independently
// - each capture raises interrupt when enabled
`timescale 1ns/1ps
`default_nettype none
module timer_clock_select
  import timer_clock_pkg::*;
(
  input  wire logic                     CLK,
  input  wire logic                     RSTN,
  input  wire timer_clock_pkg::sfr_req_t SFR_REQ,
  output logic     [7:0]                SFR_RDATA,
  input  wire logic                     EXT_CLK,
  input  wire logic                     T0_EVENT_MODE,
  input  wire logic                     T1_EVENT_MODE,
  input  wire logic                     FRAME_START,
  input  wire logic                     T2_CAPTURE,
  input  wire logic [1:0]               TIMER_IRQ_ENABLE,
  output logic                          T0_TICK,
  output logic                          T1_TICK,
  output logic     [1:0]                TIMER_IRQ
);
  import timer_clock_pkg::*;

  function automatic logic wr_hit(input sfr_req_t req, input logic [7:0] a);
    return req.wr && (req.addr == a);
  endfunction

  logic [7:0]  clock_control_reg;
  logic [3:0]  div12_reg;
  logic [1:0]  div4_reg;
  logic [1:0]  div48_reg;
  logic [2:0]  ext8_reg;
  logic        ext_meta_reg;
  logic        ext_sync_reg;
  logic        ext_prev_reg;
  logic        tick12;
  logic        tick4;
  logic        tick48;
  logic        tick_ext8;
  logic        ext_rise;
  logic        pre_tick;
  logic [7:0]  ctrl_reg   [2];
  logic [15:0] count_reg  [2];
  logic [15:0] reload_reg [2];
  logic [1:0]  lo_tick;
  logic [1:0]  hi_step;
  logic [1:0]  ovf_lo;
  logic [1:0]  ovf_hi;
  logic [1:0]  cap_evt;
  logic [1:0]  cap_trig;
  logic [7:0]  rd_mux;

  // clock-control register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clock_control_reg <= RESET_BYTE;
    end else if (wr_hit(SFR_REQ, ADDR_CLOCK_CONTROL)) begin
      clock_control_reg <= SFR_REQ.wdata;
    end
  end

  // free-running system clock dividers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div12_reg <= 4'h0;
      div4_reg  <= 2'h0;
      div48_reg <= 2'h0;
    end else begin
      div12_reg <= tick12 ? 4'h0 : div12_reg + 4'h1;
      div4_reg  <= div4_reg + 2'h1;
      if (tick12) begin
        div48_reg <= div48_reg + 2'h1;
      end
    end
  end

  assign tick12 = (div12_reg == DIV12_LAST);
  assign tick4  = (div4_reg == DIV4_LAST);
  assign tick48 = tick12 && (div48_reg == DIV48_LAST);

  // external clock: only the second and third stages are looked at, the first may be metastable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= EXT_CLK;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign ext_rise = ext_sync_reg && !ext_prev_reg;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext8_reg <= 3'h0;
    end else if (ext_rise) begin
      ext8_reg <= ext8_reg + 3'h1;
    end
  end

  // one system-clock pulse per eight external rising edges
  assign tick_ext8 = ext_rise && (ext8_reg == EXT8_LAST);

  always_comb begin
    unique case (prescale_t'(clock_control_reg[CKC_PRESCALE_LSB +: 2]))
      PRE_DIV12: pre_tick = tick12;
      PRE_DIV4:  pre_tick = tick4;
      PRE_DIV48: pre_tick = tick48;
      PRE_EXT8:  pre_tick = tick_ext8;
    endcase
  end

  // in event-count mode the counting input comes from elsewhere, so no tick here
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      T0_TICK <= 1'b0;
      T1_TICK <= 1'b0;
    end else begin
      T0_TICK <= !T0_EVENT_MODE && (clock_control_reg[CKC_TIMER0_SEL] || pre_tick);
      T1_TICK <= !T1_EVENT_MODE && (clock_control_reg[CKC_TIMER1_SEL] || pre_tick);
    end
  end

  assign cap_trig = {FRAME_START, T2_CAPTURE};

  for (genvar i = 0; i < 2; i++) begin : g_timer
    logic run;
    logic split;
    logic capture;
    logic xsel_tick;
    logic hi_tick;
    logic lo_wrap;
    logic hi_wrap;
    logic lo_reload;
    logic [7:0] lo_next;
    logic [7:0] hi_next;

    assign run       = ctrl_reg[i][CTL_RUN];
    assign split     = ctrl_reg[i][CTL_SPLIT];
    assign capture   = ctrl_reg[i][CTL_CAPTURE];
    assign xsel_tick = ctrl_reg[i][CTL_EXT_SEL] ? tick_ext8 : tick12;
    assign lo_tick[i] = run && (clock_control_reg[CKC_LOW_SEL_BASE + 2 * i] || xsel_tick);
    assign hi_tick   = run && (clock_control_reg[CKC_HIGH_SEL_BASE + 2 * i] || xsel_tick);
    assign lo_wrap   = (count_reg[i][7:0] == 8'hFF);
    assign hi_wrap   = (count_reg[i][15:8] == 8'hFF);
    // high byte follows the low carry unless split, so its select bit only matters split
    assign hi_step[i] = split ? hi_tick : (lo_tick[i] && lo_wrap);
    assign lo_reload = split ? lo_wrap : (lo_wrap && hi_wrap);
    // capture mode counts freely: a wrap goes to zero, never to the reload value
    assign lo_next = !lo_wrap ? count_reg[i][7:0] + 8'h01 :
                     (lo_reload && !capture) ? reload_reg[i][7:0] : 8'h00;
    assign hi_next = !hi_wrap ? count_reg[i][15:8] + 8'h01 :
                     capture ? 8'h00 : reload_reg[i][15:8];
    assign ovf_lo[i]  = lo_tick[i] && lo_wrap;
    assign ovf_hi[i]  = hi_step[i] && hi_wrap;
    assign cap_evt[i] = capture && cap_trig[i];

    // software write to a count byte wins over counting in the same cycle
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        count_reg[i] <= RESET_WORD;
      end else begin
        if (wr_hit(SFR_REQ, ADDR_COUNT_LOW[i])) begin
          count_reg[i][7:0] <= SFR_REQ.wdata;
        end else if (lo_tick[i]) begin
          count_reg[i][7:0] <= lo_next;
        end
        if (wr_hit(SFR_REQ, ADDR_COUNT_HIGH[i])) begin
          count_reg[i][15:8] <= SFR_REQ.wdata;
        end else if (hi_step[i]) begin
          count_reg[i][15:8] <= hi_next;
        end
      end
    end

    // a capture beats a software write to the reload bytes
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        reload_reg[i] <= RESET_WORD;
      end else if (cap_evt[i]) begin
        reload_reg[i] <= count_reg[i];
      end else begin
        if (wr_hit(SFR_REQ, ADDR_RELOAD_LOW[i])) begin
          reload_reg[i][7:0] <= SFR_REQ.wdata;
        end
        if (wr_hit(SFR_REQ, ADDR_RELOAD_HIGH[i])) begin
          reload_reg[i][15:8] <= SFR_REQ.wdata;
        end
      end
    end

    // flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        ctrl_reg[i] <= RESET_BYTE;
      end else begin
        if (wr_hit(SFR_REQ, ADDR_CONTROL[i])) begin
          ctrl_reg[i] <= SFR_REQ.wdata & CTL_WRITE_MASK;
        end
        if (ovf_hi[i] || cap_evt[i]) begin
          ctrl_reg[i][CTL_HIGH_FLAG] <= 1'b1;
        end
        if (ovf_lo[i]) begin
          ctrl_reg[i][CTL_LOW_FLAG] <= 1'b1;
        end
      end
    end

    assign TIMER_IRQ[i] = TIMER_IRQ_ENABLE[i] && (ctrl_reg[i][CTL_HIGH_FLAG] ||
                          (ctrl_reg[i][CTL_LOW_IRQ_EN] && ctrl_reg[i][CTL_LOW_FLAG]));
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (SFR_REQ.addr == ADDR_CLOCK_CONTROL) begin
      rd_mux = clock_control_reg;
    end
    for (int k = 0; k < 2; k++) begin
      if (SFR_REQ.addr == ADDR_CONTROL[k]) begin
        rd_mux = ctrl_reg[k];
      end
      if (SFR_REQ.addr == ADDR_RELOAD_LOW[k]) begin
        rd_mux = reload_reg[k][7:0];
      end
      if (SFR_REQ.addr == ADDR_RELOAD_HIGH[k]) begin
        rd_mux = reload_reg[k][15:8];
      end
      if (SFR_REQ.addr == ADDR_COUNT_LOW[k]) begin
        rd_mux = count_reg[k][7:0];
      end
      if (SFR_REQ.addr == ADDR_COUNT_HIGH[k]) begin
        rd_mux = count_reg[k][15:8];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SFR_RDATA <= RESET_BYTE;
    end else if (SFR_REQ.rd) begin
      SFR_RDATA <= rd_mux;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_gap4;
    !tick4 [*3] ##1 tick4;
  endsequence

  sequence s_t3_wrap16;
    lo_tick[1] && !ctrl_reg[1][CTL_SPLIT] && !ctrl_reg[1][CTL_CAPTURE] &&
    count_reg[1] == 16'hFFFF && !SFR_REQ.wr;
  endsequence

  a_prescale_div4:  assert property (tick4 |=> s_gap4)
    else $error("divide-by-4 tick spacing wrong");
  a_prescale_div12: assert property (tick12 |-> ##12 tick12)
    else $error("divide-by-12 tick spacing wrong");
  a_prescale_div48: assert property (tick48 |-> ##1 !tick48 ##47 tick48)
    else $error("divide-by-48 tick spacing wrong");
  a_timer0_system_clock:  assert property (clock_control_reg[CKC_TIMER0_SEL] && !T0_EVENT_MODE
                                     |=> T0_TICK)
    else $error("timer 0 not ticking on system clock");
  a_timer1_event:   assert property (T1_EVENT_MODE |=> !T1_TICK)
    else $error("timer 1 ticked in event mode");
  a_ext_synced:     assert property (tick_ext8 |-> ext_sync_reg && !$past(ext_sync_reg))
    else $error("external tick not from synchronised edge");
  a_t3_reload_flag: assert property (s_t3_wrap16 |=> count_reg[1] == $past(reload_reg[1])
                                     && ctrl_reg[1][CTL_HIGH_FLAG])
    else $error("timer 3 16-bit reload or flag missing");
  a_t3_capture:     assert property (ctrl_reg[1][CTL_CAPTURE] && FRAME_START
                                     |=> reload_reg[1] == $past(count_reg[1]))
    else $error("timer 3 frame capture missing");
  a_t3_irq_raise:   assert property (ovf_hi[1] && TIMER_IRQ_ENABLE[1] && !SFR_REQ.wr
                                     ##1 TIMER_IRQ_ENABLE[1] |-> TIMER_IRQ[1])
    else $error("timer 3 overflow did not interrupt");
  a_t2_high_read:   assert property (SFR_REQ.rd && SFR_REQ.addr == ADDR_COUNT_HIGH[0]
                                     |=> SFR_RDATA == $past(count_reg[0][15:8]))
    else $error("timer 2 high byte read wrong");

endmodule
`default_nettype wire

// [timer_clock_pkg.sv]
// package: register map, field positions and prescale constants for the timer clock block
package timer_clock_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;

  // register byte addresses; index [0] is timer 2, index [1] is timer 3
  localparam logic [7:0]      ADDR_CLOCK_CONTROL = 8'h8E;
  localparam logic [1:0][7:0] ADDR_CONTROL       = {8'h91, 8'hC8};
  localparam logic [1:0][7:0] ADDR_RELOAD_LOW    = {8'h92, 8'hCA};
  localparam logic [1:0][7:0] ADDR_RELOAD_HIGH   = {8'h93, 8'hCB};
  localparam logic [1:0][7:0] ADDR_COUNT_LOW     = {8'h94, 8'hCC};
  localparam logic [1:0][7:0] ADDR_COUNT_HIGH    = {8'h95, 8'hCD};

  // clock-control fields
  localparam int unsigned CKC_PRESCALE_LSB = 0;
  localparam int unsigned CKC_TIMER0_SEL   = 2;
  localparam int unsigned CKC_TIMER1_SEL   = 3;
  localparam int unsigned CKC_LOW_SEL_BASE = 4; // + 2 * timer index
  localparam int unsigned CKC_HIGH_SEL_BASE = 5; // + 2 * timer index

  // timer control fields (same layout for timer 2 and timer 3)
  localparam int unsigned CTL_HIGH_FLAG   = 7;
  localparam int unsigned CTL_LOW_FLAG    = 6;
  localparam int unsigned CTL_LOW_IRQ_EN  = 5;
  localparam int unsigned CTL_CAPTURE     = 4;
  localparam int unsigned CTL_SPLIT       = 3;
  localparam int unsigned CTL_RUN         = 2;
  localparam int unsigned CTL_EXT_SEL     = 0;
  localparam logic [7:0]  CTL_WRITE_MASK  = 8'hFD;

  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [15:0] RESET_WORD      = 16'h0000;

  // prescale field codes and divisors
  typedef enum logic [1:0] {
    PRE_DIV12 = 2'b00,
    PRE_DIV4  = 2'b01,
    PRE_DIV48 = 2'b10,
    PRE_EXT8  = 2'b11
  } prescale_t;

  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [1:0] DIV48_LAST = 2'h3; // four div-12 periods
  localparam logic [2:0] EXT8_LAST  = 3'h7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

endpackage

// [timer_clock_select_test.sv]
// self-checking testbench for the timer clock select block
`timescale 1ns/1ps
`default_nettype none
module timer_clock_select_test;
  import timer_clock_pkg::*;
  logic       clk         = 1'b0;
  logic       rstn        = 1'b0;
  sfr_req_t   req         = '0;
  logic [7:0] rdata;
  logic       ext_clk     = 1'b0;
  logic [1:0] ev_mode     = 2'b00;
  logic       frame_start = 1'b0;
  logic       t2_cap      = 1'b0;
  logic [1:0] irq_en      = 2'b00;
  logic       t0_tick;
  logic       t1_tick;
  logic [1:0] irq;
  int         fail_count  = 0;
  int         num_checks  = 0;
  int         cycles      = 0;
  int         ext_div     = 0;
  int         seed        = 32'hF33C50B9;
  logic [7:0] exp_q[$];
  logic [7:0] adr_q[$];
  logic       rd_pend     = 1'b0;

  timer_clock_select DUT (
    .CLK              (clk),
    .RSTN             (rstn),
    .SFR_REQ          (req),
    .SFR_RDATA        (rdata),
    .EXT_CLK          (ext_clk),
    .T0_EVENT_MODE    (ev_mode[0]),
    .T1_EVENT_MODE    (ev_mode[1]),
    .FRAME_START      (frame_start),
    .T2_CAPTURE       (t2_cap),
    .TIMER_IRQ_ENABLE (irq_en),
    .T0_TICK          (t0_tick),
    .T1_TICK          (t1_tick),
    .TIMER_IRQ        (irq)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // hang guard: whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  // external oscillator: period of six system cycles
  always @(posedge clk) begin
    ext_div <= (ext_div == 2) ? 0 : ext_div + 1;
    if (ext_div == 2) begin
      ext_clk <= ~ext_clk;
    end
  end

  // read data lands one cycle after the read strobe edge
  always @(posedge clk) begin
    if (rd_pend) begin
      check($sformatf("reg %h", adr_q[0]), {8'h00, rdata}, {8'h00, exp_q[0]});
      void'(exp_q.pop_front());
      void'(adr_q.pop_front());
    end
    rd_pend <= req.rd;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req.rd <= 1'b0;
  endtask

  task automatic cap(input int i);
    @(posedge clk) {frame_start, t2_cap} <= (i == 1) ? 2'b10 : 2'b01;
    @(posedge clk) {frame_start, t2_cap} <= 2'b00;
  endtask

  task automatic irq_chk(input int i, input logic e);
    #1;
    check("irq", {15'h0000, irq[i]}, {15'h0000, e});
  endtask

  initial begin
    logic [7:0] lo;
    logic [7:0] hi;
    int         n0;
    int         n1;
    logic [7:0] ctl_t[6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h08, 8'h04};
    int         e0[6]    = '{8, 24, 2, 2, 0, 96};
    int         e1[6]    = '{96, 96, 96, 96, 0, 8};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_CLOCK_CONTROL, 8'h00);
    rd(ADDR_RELOAD_LOW[0], 8'h00);
    lo = 8'($random(seed));
    wr(ADDR_CLOCK_CONTROL, lo);
    rd(ADDR_CLOCK_CONTROL, lo);
    wr(ADDR_RELOAD_HIGH[0], ~lo);
    rd(ADDR_RELOAD_HIGH[0], ~lo);
    $display("test registers done");
    // windows span whole prescale periods, so counts are phase independent
    for (int k = 0; k < 6; k++) begin
      @(posedge clk) ev_mode <= {2{k == 4}};
      wr(ADDR_CLOCK_CONTROL, ctl_t[k]);
      repeat (60) @(posedge clk);
      n0 = 0;
      n1 = 0;
      repeat (96) begin
        @(posedge clk);
        #1;
        n0 += int'(t0_tick);
        n1 += int'(t1_tick);
      end
      check("t0 ticks", 16'(n0), 16'(e0[k]));
      check("t1 ticks", 16'(n1), 16'(e1[k]));
    end
    $display("test ticks done");
    // start at the wrap point: the read lands two edges after the run bit
    wr(ADDR_CLOCK_CONTROL, 8'h40);
    wr(ADDR_COUNT_LOW[1], 8'hFF);
    wr(ADDR_COUNT_HIGH[1], 8'hFF);
    wr(ADDR_RELOAD_LOW[1], 8'h34);
    wr(ADDR_RELOAD_HIGH[1], 8'h12);
    @(posedge clk) irq_en <= 2'b10;
    wr(ADDR_CONTROL[1], 8'h04);
    rd(ADDR_CONTROL[1], 8'hC4);
    irq_chk(1, 1'b1);
    wr(ADDR_CONTROL[1], 8'h00);
    irq_chk(1, 1'b0);
    rd(ADDR_COUNT_HIGH[1], 8'h12);
    wr(ADDR_COUNT_LOW[1], 8'hFF);
    wr(ADDR_COUNT_HIGH[1], 8'h00);
    wr(ADDR_CONTROL[1], 8'h24);
    rd(ADDR_CONTROL[1], 8'h64);
    irq_chk(1, 1'b1);
    wr(ADDR_CONTROL[1], 8'h24);
    irq_chk(1, 1'b0);
    wr(ADDR_CONTROL[1], 8'h00);
    $display("test overflow done");
    // split: high byte on system clock steps every edge, low byte barely moves
    wr(ADDR_CLOCK_CONTROL, 8'h80);
    wr(ADDR_COUNT_LOW[1], 8'h00);
    wr(ADDR_COUNT_HIGH[1], 8'hFF);
    wr(ADDR_RELOAD_HIGH[1], 8'h56);
    wr(ADDR_CONTROL[1], 8'h0C);
    rd(ADDR_CONTROL[1], 8'h8C);
    wr(ADDR_CONTROL[1], 8'h08);
    rd(ADDR_COUNT_HIGH[1], 8'h59);
    $display("test split done");
    for (int i = 0; i < 2; i++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      wr(ADDR_COUNT_LOW[i], lo);
      wr(ADDR_COUNT_HIGH[i], hi);
      wr(ADDR_CONTROL[i], 8'h10);
      cap(i);
      rd(ADDR_RELOAD_LOW[i], lo);
      rd(ADDR_RELOAD_HIGH[i], hi);
      rd(ADDR_COUNT_HIGH[i], hi);
      rd(ADDR_CONTROL[i], 8'h90);
      @(posedge clk) irq_en <= 2'b11;
      irq_chk(i, 1'b1);
      wr(ADDR_CONTROL[i], 8'h00);
      wr(ADDR_COUNT_LOW[i], ~lo);
      cap(i);
      rd(ADDR_RELOAD_LOW[i], lo);
    end
    $display("test capture done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
